// ### tpk_timer.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tpk_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic enable_pin,
  input wire logic kill,
  input wire logic wake_restore,
  output logic cmp_out,
  output logic tc_out,
  output logic irq
);
  // Register state of the block, apart from the kill hold and dead band units
  typedef struct packed {
    logic [15:0] cfg_pri; // timer_config_primary
    logic [15:0] cfg_sec; // timer_config_secondary
    logic [15:0] period; // Reload value
    logic [15:0] cmp_wr; // Compare value as written
    logic [15:0] cmp_act; // Compare value in use
    logic [15:0] count; // Down counter
    logic [15:0] capture; // Captured count
    logic [3:0] flags; // Sticky interrupt flags
    logic [3:0] mask; // Interrupt enables
    logic started; // Period mode saw first edge
    logic pin_q; // Previous enable pin level
    logic en_q; // Previous enable bit
    logic cmp_q; // Previous compare result
    logic [15:0] rdata; // Read answer
    logic irq; // Interrupt line
    logic cmp_out; // Compare pin
    logic tc_out; // Terminal count pin
  } tpk_tmr_st_t;

  tpk_tmr_st_t q;
  tpk_tmr_st_t d;

  // Decoded configuration
  logic en;
  logic single;
  logic comp_mode;
  logic buffered;
  logic db_en;
  logic irq_sel;
  logic [3:0] db_len;
  tpk_pkg::tpk_sub_t sub;
  tpk_pkg::tpk_cmp_t ctype;

  // Pin edges
  logic pin_rise;
  logic pin_fall;

  // Counting control
  logic gate;
  logic counting;
  logic tc;
  logic cmp_raw;

  // Kill and dead band results
  logic kill_block;
  logic db_p;
  logic db_n;

  // Bus write strobes per register
  logic wr_pri;
  logic wr_sec;
  logic wr_per;
  logic wr_cmp;
  logic wr_sr;

  // Event and stop terms
  logic [3:0] ev;
  logic stop;

  assign en = q.cfg_pri[tpk_pkg::CP_EN];
  assign single = q.cfg_pri[tpk_pkg::CP_SINGLE];
  assign comp_mode = q.cfg_pri[tpk_pkg::CP_MODE];
  assign buffered = q.cfg_pri[tpk_pkg::CP_BUF];
  assign db_en = q.cfg_pri[tpk_pkg::CP_DB] && comp_mode;
  assign db_len = q.cfg_pri[tpk_pkg::CP_DBL_LSB +: tpk_pkg::DBL_W];
  assign irq_sel = q.cfg_sec[tpk_pkg::CS_IRQ_SEL];
  assign sub = tpk_pkg::tpk_sub_t'(q.cfg_sec[tpk_pkg::CS_SUB_LSB +: 3]);
  assign ctype = tpk_pkg::tpk_cmp_t'(q.cfg_sec[tpk_pkg::CS_TYPE_LSB +: 3]);

  assign pin_rise = enable_pin && !q.pin_q;
  assign pin_fall = !enable_pin && q.pin_q;

  assign wr_pri = wr && (addr == tpk_pkg::ADDR_CFG_PRI);
  assign wr_sec = wr && (addr == tpk_pkg::ADDR_CFG_SEC);
  assign wr_per = wr && (addr == tpk_pkg::ADDR_PERIOD);
  assign wr_cmp = wr && (addr == tpk_pkg::ADDR_CNT_CMP);
  assign wr_sr = wr && (addr == tpk_pkg::ADDR_STATUS);

  // Which sub-mode lets the counter run
  always_comb begin
    if (comp_mode) begin
      gate = 1'b1;
    end else begin
      case (sub)
        tpk_pkg::TPK_SUB_PWIDTH: gate = enable_pin;
        tpk_pkg::TPK_SUB_PERIOD: gate = q.started;
        default: gate = 1'b1;
      endcase
    end
  end

  // Count only while enabled; this stands in for the gated block clock
  assign counting = en && gate;
  assign tc = counting && (q.count == tpk_pkg::ZERO16);

  // Match condition against the compare value in use
  always_comb begin
    case (ctype)
      tpk_pkg::TPK_CMP_EQ: cmp_raw = q.count == q.cmp_act;
      tpk_pkg::TPK_CMP_LT: cmp_raw = q.count < q.cmp_act;
      tpk_pkg::TPK_CMP_LE: cmp_raw = q.count <= q.cmp_act;
      tpk_pkg::TPK_CMP_GT: cmp_raw = q.count > q.cmp_act;
      tpk_pkg::TPK_CMP_GE: cmp_raw = q.count >= q.cmp_act;
      default: cmp_raw = 1'b0;
    endcase
  end

  // Kill release delay
  tpk_kill_hold u_kill (
    .mclk(mclk),
    .rst(rst),
    .kill(kill),
    .block(kill_block)
  );

  // Dead band splitter; a zero length passes the level straight on
  tpk_dead_band u_db (
    .mclk(mclk),
    .rst(rst),
    .cmp_in(comp_mode && en && cmp_raw),
    .freeze(kill_block),
    .length(db_en ? db_len : tpk_pkg::DBL_ZERO),
    .out_p(db_p),
    .out_n(db_n)
  );

  // Next-state logic of the block, apart from the kill hold and dead band units
  always_comb begin
    d = q;
    ev = '0;
    stop = 1'b0;
    d.pin_q = enable_pin;
    d.en_q = en;
    d.cmp_q = cmp_raw;

    // Register writes
    if (wr_pri) begin
      d.cfg_pri = wdata;
    end
    if (wr_sec) begin
      d.cfg_sec = wdata;
    end
    if (wr_per) begin
      d.period = wdata;
    end
    if (wr_cmp) begin
      // Shared address always writes the compare value
      d.cmp_wr = wdata;
    end
    if (wr_sr) begin
      d.mask = wdata[tpk_pkg::SR_MASK_LSB +: tpk_pkg::NIRQ];
    end

    // Unbuffered compare value follows the write at once
    if (!buffered) begin
      d.cmp_act = d.cmp_wr;
    end

    // Counter
    if (counting) begin
      if (tc) begin
        ev[tpk_pkg::IRQ_TC] = 1'b1;
        if (buffered) begin
          // New compare value only from the next period
          d.cmp_act = d.cmp_wr;
        end
        if (single) begin
          // No reload, the block stops here
          stop = 1'b1;
        end else begin
          d.count = q.period;
        end
      end else begin
        d.count = q.count - tpk_pkg::ONE16;
      end
    end

    // Compare event on a rising match
    if (comp_mode && counting && cmp_raw && !q.cmp_q) begin
      ev[tpk_pkg::IRQ_CMP] = 1'b1;
    end

    // Timer sub-modes driven by the enable pin
    if (!comp_mode && en) begin
      case (sub)
        tpk_pkg::TPK_SUB_CAPT: begin
          if (pin_rise) begin
            d.capture = q.count;
            ev[tpk_pkg::IRQ_CMP] = 1'b1;
          end
        end
        tpk_pkg::TPK_SUB_PWIDTH: begin
          if (pin_fall) begin
            d.capture = q.count;
            ev[tpk_pkg::IRQ_CMP] = 1'b1;
            stop = stop || single;
          end
        end
        tpk_pkg::TPK_SUB_PERIOD: begin
          if (pin_rise) begin
            if (!q.started) begin
              // First edge starts the measurement
              d.started = 1'b1;
              d.count = q.period;
            end else begin
              d.capture = q.count;
              ev[tpk_pkg::IRQ_CMP] = 1'b1;
              stop = stop || single;
            end
          end
        end
        default: begin
          // Free run and stop-on-interrupt need no pin action
        end
      endcase
    end

    // Enable event from the rising enable bit
    if (en && !q.en_q) begin
      ev[tpk_pkg::IRQ_EN] = 1'b1;
    end

    // Stop-on-interrupt ends on any enabled source
    if (!comp_mode && en && sub == tpk_pkg::TPK_SUB_IRQ) begin
      if ((ev & q.mask) != '0) begin
        stop = 1'b1;
      end
    end

    // Hardware stop clears the enable bit until software sets it again
    if (stop) begin
      ev[tpk_pkg::IRQ_STOP] = 1'b1;
      d.started = 1'b0;
      if (!(wr_pri && wdata[tpk_pkg::CP_EN])) begin
        d.cfg_pri[tpk_pkg::CP_EN] = 1'b0;
      end
    end
    if (!d.cfg_pri[tpk_pkg::CP_EN]) begin
      d.started = 1'b0;
    end

    // Sticky flags: write one clears, a new event wins the same cycle
    if (wr_sr) begin
      d.flags = q.flags & ~wdata[tpk_pkg::SR_FLAG_LSB +: tpk_pkg::NIRQ];
    end
    d.flags = d.flags | ev;

    // Interrupt line
    if (irq_sel) begin
      // Level while any enabled flag stays set
      d.irq = (d.flags & q.mask) != '0;
    end else begin
      // One pulse per occurrence, no wait for clearing
      d.irq = (ev & q.mask) != '0;
    end

    // Count is not kept across a wake from low power
    if (wake_restore) begin
      d.count = tpk_pkg::ZERO16;
    end

    // Pin outputs
    if (kill_block && comp_mode) begin
      d.cmp_out = 1'b0;
      d.tc_out = 1'b0;
    end else if (comp_mode) begin
      d.cmp_out = db_p;
      d.tc_out = db_en ? db_n : tc;
    end else begin
      d.cmp_out = 1'b0;
      d.tc_out = tc;
    end

    // Read answer, one cycle after the strobe
    d.rdata = tpk_pkg::ZERO16;
    if (rd) begin
      case (addr)
        tpk_pkg::ADDR_CFG_PRI: d.rdata = q.cfg_pri;
        tpk_pkg::ADDR_CFG_SEC: d.rdata = q.cfg_sec;
        tpk_pkg::ADDR_PERIOD: d.rdata = q.period;
        tpk_pkg::ADDR_CNT_CMP: begin
          // Count cannot be seen in comparator mode
          d.rdata = comp_mode ? q.cmp_wr : q.count;
        end
        tpk_pkg::ADDR_CAPTURE: d.rdata = q.capture;
        tpk_pkg::ADDR_STATUS: begin
          d.rdata[tpk_pkg::SR_FLAG_LSB +: tpk_pkg::NIRQ] = q.flags;
          d.rdata[tpk_pkg::SR_MASK_LSB +: tpk_pkg::NIRQ] = q.mask;
        end
        default: d.rdata = tpk_pkg::ZERO16;
      endcase
    end
  end

  // State register; the kill source keeps kill high a full cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.period <= tpk_pkg::PER_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign cmp_out = q.cmp_out;
  assign tc_out = q.tc_out;
  assign irq = q.irq;

endmodule : tpk_timer
`default_nettype wire

// ### tpk_pkg.sv
package tpk_pkg;
  // Data and address widths of the register port, and width of the dead band length
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 3;
  localparam int unsigned DBL_W = 4;
  // Register offsets
  localparam logic [2:0] ADDR_CFG_PRI = 3'h0;
  localparam logic [2:0] ADDR_CFG_SEC = 3'h1;
  localparam logic [2:0] ADDR_PERIOD = 3'h2;
  localparam logic [2:0] ADDR_CNT_CMP = 3'h3;
  localparam logic [2:0] ADDR_CAPTURE = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  // Fields of timer_config_primary
  localparam int unsigned CP_EN = 0;
  localparam int unsigned CP_SINGLE = 1;
  localparam int unsigned CP_MODE = 2;
  localparam int unsigned CP_BUF = 3;
  localparam int unsigned CP_DB = 4;
  localparam int unsigned CP_DBL_LSB = 8;
  // Fields of timer_config_secondary
  localparam int unsigned CS_TYPE_LSB = 0;
  localparam int unsigned CS_IRQ_SEL = 3;
  localparam int unsigned CS_SUB_LSB = 4;
  // Fields of timer_status_mask
  localparam int unsigned SR_FLAG_LSB = 0;
  localparam int unsigned SR_MASK_LSB = 4;
  localparam int unsigned NIRQ = 4;
  // Interrupt source indices
  localparam int unsigned IRQ_TC = 0;
  localparam int unsigned IRQ_CMP = 1;
  localparam int unsigned IRQ_EN = 2;
  localparam int unsigned IRQ_STOP = 3;
  // Reset value of the period, and other fixed constants
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [3:0] DBL_ONE = 4'h1;
  localparam logic [3:0] DBL_ZERO = 4'h0;
  // Cycles the outputs stay forced after kill drops
  localparam logic [1:0] KILL_HOLD = 2'h1;
  localparam logic [1:0] KILL_ZERO = 2'h0;
  // Compare types
  typedef enum logic [2:0] {
    TPK_CMP_EQ, TPK_CMP_LT, TPK_CMP_LE, TPK_CMP_GT, TPK_CMP_GE
  } tpk_cmp_t;
  // Timer sub-modes outside comparator mode
  typedef enum logic [2:0] {
    TPK_SUB_FREE, TPK_SUB_CAPT, TPK_SUB_PWIDTH, TPK_SUB_PERIOD, TPK_SUB_IRQ
  } tpk_sub_t;
endpackage : tpk_pkg

// ### tpk_kill_hold.sv
`timescale 1ns/1ps
`default_nettype none
// Stretches the kill input so outputs come back a fixed time after release
module tpk_kill_hold (
  input wire logic mclk,
  input wire logic rst,
  input wire logic kill,
  output logic block
);
  typedef struct packed {
    logic [1:0] hold; // Cycles left after release
  } tpk_kh_st_t;
  tpk_kh_st_t q;
  tpk_kh_st_t d;
  // Kill takes effect at once, release is delayed
  assign block = kill || (q.hold != tpk_pkg::KILL_ZERO);
  // Next-state logic
  always_comb begin
    d = q;
    if (kill) begin
      d.hold = tpk_pkg::KILL_HOLD;
    end else if (q.hold != tpk_pkg::KILL_ZERO) begin
      d.hold = q.hold - 2'h1;
    end
  end
  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : tpk_kill_hold
`default_nettype wire

// ### tpk_dead_band.sv
`timescale 1ns/1ps
`default_nettype none
// Splits one compare level into two non-overlapping outputs
module tpk_dead_band (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmp_in,
  input wire logic freeze,
  input wire logic [3:0] length,
  output logic out_p,
  output logic out_n
);
  typedef struct packed {
    logic prev; // Last seen compare level
    logic [3:0] cnt; // Dead time still to run
    logic target; // Level to show when time ends
    logic p; // True output
    logic n; // Complement output
  } tpk_db_st_t;
  tpk_db_st_t q;
  tpk_db_st_t d;
  assign out_p = q.p;
  assign out_n = q.n;
  // Edges are always tracked so edges seen while frozen are lost
  always_comb begin
    d = q;
    d.prev = cmp_in;
    if (!freeze) begin
      if (q.cnt != tpk_pkg::DBL_ZERO) begin
        // Changes while counting are ignored
        d.cnt = q.cnt - tpk_pkg::DBL_ONE;
        if (q.cnt == tpk_pkg::DBL_ONE) begin
          d.p = q.target;
          d.n = ~q.target;
        end
      end else if (cmp_in != q.prev) begin
        if (length == tpk_pkg::DBL_ZERO) begin
          // No dead time: follow directly
          d.p = cmp_in;
          d.n = ~cmp_in;
        end else begin
          // Both low for the dead time
          d.p = 1'b0;
          d.n = 1'b0;
          d.cnt = length;
          d.target = cmp_in;
        end
      end
    end
  end
  // State register, complement idles high
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.n <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule : tpk_dead_band
`default_nettype wire

// ### tpk_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level properties of the timer; bus writes are shadowed to know the mode
module tpk_timer_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic kill,
  input wire logic cmp_out,
  input wire logic tc_out,
  input wire logic irq
);
  // Shadow copies of the written registers
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] sec;
    logic [15:0] per;
    logic [15:0] cmp;
  } tpk_shadow_t;
  tpk_shadow_t s_q;
  tpk_shadow_t s_d;
  logic comp;
  logic dbon;
  logic stw;
  // Enable may self-clear in the design; only the mode, buffer and dead band fields are used here
  assign comp = s_q.cfg[tpk_pkg::CP_MODE];
  assign dbon = s_q.cfg[tpk_pkg::CP_DB];
  // Writes that may legally change the interrupt line
  assign stw = wr && (addr == tpk_pkg::ADDR_STATUS || addr == tpk_pkg::ADDR_CFG_SEC);
  // Next shadow from bus writes
  always_comb begin
    s_d = s_q;
    if (wr && addr == tpk_pkg::ADDR_CFG_PRI) s_d.cfg = wdata;
    if (wr && addr == tpk_pkg::ADDR_CFG_SEC) s_d.sec = wdata;
    if (wr && addr == tpk_pkg::ADDR_PERIOD) s_d.per = wdata;
    if (wr && addr == tpk_pkg::ADDR_CNT_CMP) s_d.cmp = wdata;
  end
  // Shadow register, same reset values as the block
  always_ff @(posedge mclk) begin
    if (rst) s_q <= '{cfg: 16'h0000, sec: 16'h0000, per: tpk_pkg::PER_RST, cmp: 16'h0000};
    else s_q <= s_d;
  end
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
    !$past(rd) |-> rdata == tpk_pkg::ZERO16) else $error("read data not zero outside read");
  a_shared_read: assert property (@(posedge mclk) disable iff (rst)
    comp && !s_q.cfg[tpk_pkg::CP_BUF] && rd && addr == tpk_pkg::ADDR_CNT_CMP |=> rdata == s_q.cmp)
    else $error("shared address did not return compare");
  a_period_read: assert property (@(posedge mclk) disable iff (rst)
    rd && addr == tpk_pkg::ADDR_PERIOD |=> rdata == s_q.per) else $error("period value lost");
  a_kill_low: assert property (@(posedge mclk) disable iff (rst)
    comp && $past(kill) |-> !cmp_out && !(dbon && tc_out)) else $error("outputs active under kill");
  a_kill_hold: assert property (@(posedge mclk) disable iff (rst)
    comp && $fell(kill) |-> !cmp_out ##1 !cmp_out) else $error("outputs restored too early");
  a_no_overlap: assert property (@(posedge mclk) disable iff (rst)
    comp && dbon |-> !(cmp_out && tc_out)) else $error("dead band outputs overlap");
  a_dead_time: assert property (@(posedge mclk) disable iff (rst)
    comp && dbon && s_q.cfg[11:8] == 4'h2 && $rose(cmp_out) |-> !$past(tc_out) && !$past(tc_out, 2))
    else $error("dead time shorter than set");
  a_status_level: assert property (@(posedge mclk) disable iff (rst)
    s_q.sec[tpk_pkg::CS_IRQ_SEL] && irq && !stw && !$past(stw) |=> irq) else $error("status irq dropped");
  a_raw_pulse: assert property (@(posedge mclk) disable iff (rst)
    !s_q.sec[tpk_pkg::CS_IRQ_SEL] && irq && !$past(stw) |=> !irq) else $error("raw irq not a pulse");
endmodule : tpk_timer_checker
bind tpk_timer tpk_timer_checker chk_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .kill(kill), .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));
`default_nettype wire

// ### tpk_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// Interrupt controller and fault source beside the timer
module tpk_fabric_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq,
  input wire logic cmp_out,
  input wire logic kill_go,
  input wire logic [3:0] kill_len,
  output var logic kill,
  output int irq_rises,
  output int cmp_rises
);
  logic irq_l;
  logic cmp_l;
  logic [3:0] left;
  // Edge counters and kill stretcher
  always @(posedge mclk) begin
    if (rst) begin
      irq_rises <= 0;
      cmp_rises <= 0;
      kill <= 1'b0;
      left <= 4'h0;
    end else begin
      if (irq && !irq_l) irq_rises <= irq_rises + 1;
      if (cmp_out && !cmp_l) cmp_rises <= cmp_rises + 1;
      // A fault source never pulses shorter than one clock
      kill <= kill_go || left > 4'h1;
      if (kill_go) left <= (kill_len == 4'h0) ? 4'h1 : kill_len;
      else if (left != 4'h0) left <= left - 4'h1;
    end
    irq_l <= irq;
    cmp_l <= cmp_out;
  end
endmodule : tpk_fabric_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the timer block
module tb_top;
  logic mclk, rst, wr, rd, kill, wake_restore, cmp_out, tc_out, irq, kill_go, en_pin;
  logic [2:0] addr;
  logic [15:0] wdata, rdata;
  logic [3:0] kill_len;
  int irq_rises, cmp_rises, err_count, num_checks, base;
  tpk_timer dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .enable_pin(en_pin), .kill(kill), .wake_restore(wake_restore), .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));
  tpk_fabric_model fab_u (.mclk(mclk), .rst(rst), .irq(irq), .cmp_out(cmp_out), .kill_go(kill_go),
    .kill_len(kill_len), .kill(kill), .irq_rises(irq_rises), .cmp_rises(cmp_rises));
  // Compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Returns just after the edge so that outputs launched there have settled
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle
  // One-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  // Bounded wait on the compare pin
  task automatic wait_cmp(input logic v);
    int i;
    for (i = 0; i < 300 && cmp_out !== v; i++) @(posedge mclk);
    chk(16'(cmp_out), 16'(v));
  endtask : wait_cmp
  // Reset values and unmapped places
  task automatic t_reset;
    rd_chk(tpk_pkg::ADDR_PERIOD, tpk_pkg::PER_RST);
    rd_chk(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
    wr_reg(3'h7, 16'h1234);
    rd_chk(3'h7, 16'h0000);
    rd_chk(3'h6, 16'h0000);
  endtask : t_reset
  // Shared address and wake retention
  task automatic t_retain;
    wr_reg(tpk_pkg::ADDR_PERIOD, 16'h0008);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0004);
    wr_reg(tpk_pkg::ADDR_CNT_CMP, 16'h0003);
    rd_chk(tpk_pkg::ADDR_CNT_CMP, 16'h0003);
    @(posedge mclk) wake_restore <= 1'b1;
    @(posedge mclk) wake_restore <= 1'b0;
    rd_chk(tpk_pkg::ADDR_PERIOD, 16'h0008);
    rd_chk(tpk_pkg::ADDR_CNT_CMP, 16'h0003);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
    rd_chk(tpk_pkg::ADDR_CNT_CMP, 16'h0000);
  endtask : t_retain
  // Single run stops, clears enable, and runs again only on software request
  task automatic t_single;
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0001);
    idle(5);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0003);
    idle(30);
    rd_chk(tpk_pkg::ADDR_CFG_PRI, 16'h0002);
    rd_chk(tpk_pkg::ADDR_CNT_CMP, 16'h0000);
    rd_chk(tpk_pkg::ADDR_STATUS, 16'h000d);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h000f);
    rd_chk(tpk_pkg::ADDR_STATUS, 16'h0000);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0003);
    idle(30);
    rd_chk(tpk_pkg::ADDR_STATUS, 16'h000d);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h000f);
  endtask : t_single
  // Raw pulses, status level, masking
  task automatic t_irq;
    wr_reg(tpk_pkg::ADDR_PERIOD, 16'h0010);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h0010);
    base = irq_rises;
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0001);
    idle(60);
    chk(16'(irq_rises - base >= 3), 16'h0001);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
    wr_reg(tpk_pkg::ADDR_CFG_SEC, 16'h0008);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h0011);
    idle(2);
    chk(16'(irq), 16'h0000);
    base = irq_rises;
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0001);
    idle(60);
    chk(16'(irq_rises - base), 16'h0001);
    chk(16'(irq), 16'h0001);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h0000);
    idle(2);
    chk(16'(irq), 16'h0000);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h000f);
  endtask : t_irq
  // Dead band, kill, and every compare type
  task automatic t_comp;
    int t;
    wr_reg(tpk_pkg::ADDR_PERIOD, 16'h0020);
    wr_reg(tpk_pkg::ADDR_CNT_CMP, 16'h0010);
    wr_reg(tpk_pkg::ADDR_CFG_SEC, 16'h0001);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0215);
    wait_cmp(1'b1);
    idle(1);
    chk(16'(tc_out), 16'h0000);
    wait_cmp(1'b0);
    idle(4);
    chk(16'(tc_out), 16'h0001);
    wait_cmp(1'b1);
    idle(4);
    @(posedge mclk) kill_go <= 1'b1;
    @(posedge mclk) kill_go <= 1'b0;
    idle(2);
    chk(16'(cmp_out | tc_out), 16'h0000);
    idle(8);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0015);
    for (t = 0; t < 5; t++) begin
      wr_reg(tpk_pkg::ADDR_CFG_SEC, 16'(t));
      base = cmp_rises;
      idle(80);
      chk(16'(cmp_rises != base), 16'h0001);
    end
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
  endtask : t_comp
  // Compare value rewritten after a match: second match only when unbuffered
  task automatic t_cmp_update;
    int b;
    for (b = 0; b < 2; b++) begin
      wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
      wr_reg(tpk_pkg::ADDR_CNT_CMP, 16'h0010);
      wr_reg(tpk_pkg::ADDR_CFG_SEC, 16'h0000);
      wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0005 | 16'(b << 3));
      wait_cmp(1'b1);
      wr_reg(tpk_pkg::ADDR_CNT_CMP, 16'h0008);
      base = cmp_rises;
      idle(12);
      chk(16'(cmp_rises - base), 16'(1 - b));
    end
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0000);
  endtask : t_cmp_update
  // Period measurement in single run: capture, stop, count lost on wake
  task automatic t_period;
    wr_reg(tpk_pkg::ADDR_PERIOD, 16'h0100);
    wr_reg(tpk_pkg::ADDR_CFG_SEC, 16'h0030);
    wr_reg(tpk_pkg::ADDR_CFG_PRI, 16'h0003);
    @(posedge mclk) en_pin <= 1'b1;
    @(posedge mclk) en_pin <= 1'b0;
    idle(9);
    @(posedge mclk) en_pin <= 1'b1;
    @(posedge mclk) en_pin <= 1'b0;
    idle(2);
    rd_chk(tpk_pkg::ADDR_CFG_PRI, 16'h0002);
    rd_chk(tpk_pkg::ADDR_CAPTURE, 16'h00f6);
    rd_chk(tpk_pkg::ADDR_CNT_CMP, 16'h00f5);
    @(posedge mclk) wake_restore <= 1'b1;
    @(posedge mclk) wake_restore <= 1'b0;
    rd_chk(tpk_pkg::ADDR_CNT_CMP, 16'h0000);
    wr_reg(tpk_pkg::ADDR_STATUS, 16'h000f);
  endtask : t_period
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog against a hang
  initial begin
    #(20 * 20000);
    err_count++;
    final_report();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wake_restore = 1'b0;
    kill_go = 1'b0;
    en_pin = 1'b0;
    kill_len = 4'h3;
    err_count = 0;
    num_checks = 0;
    idle(8);
    rst <= 1'b0;
    t_reset();
    t_retain();
    t_single();
    t_irq();
    t_comp();
    t_cmp_update();
    t_period();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
